// ---- common/gwg_defines.svh ----
// address map, reset values and timing constants of the pad waveform block
`ifndef GWG_DEFINES_SVH
`define GWG_DEFINES_SVH
`define GWG_A_LVL_LO   16'h1070
`define GWG_A_LVL_HI   16'h1071
`define GWG_A_SET_LO   16'h1072
`define GWG_A_TGL_LO   16'h1073
`define GWG_A_CLR_LO   16'h1074
`define GWG_A_SET_HI   16'h1075
`define GWG_A_TGL_HI   16'h1076
`define GWG_A_CLR_HI   16'h1077
`define GWG_A_DIR_LO   16'h1078
`define GWG_A_DIR_HI   16'h1079
`define GWG_A_CFG      16'h107a
`define GWG_A_DIV      16'h107b
`define GWG_A_DSEL     16'h107c
`define GWG_A_FRAME    16'h107d
`define GWG_A_FLASH    16'h107e
`define GWG_A_CHAIN    16'h107f
`define GWG_A_PAUSE    16'h1080
`define GWG_A_ABORT    16'h1081
`define GWG_A_FLG_LO   16'h1082
`define GWG_A_FLG_HI   16'h1083
`define GWG_A_MSK_LO   16'h1084
`define GWG_A_MSK_HI   16'h1085
`define GWG_A_KIND     16'h1086
`define GWG_A_EDG_LO   16'h1087
`define GWG_A_EDG_HI   16'h1088
`define GWG_A_N_BASE   16'h1090
`define GWG_A_T_BASE   16'h10a0
`define GWG_SUBS       5
`define GWG_LAST_SUB   3'h4
`define GWG_CFG_LSB    4
`define GWG_PAUSE_RST  8'hff
`define GWG_MASK_RST   12'hfff
`endif

// ---- common/gwg_pkg.sv ----
// types of the pad waveform block
package gwg_pkg;
  typedef enum logic [3:0] {
    GWG_IDLE = 4'b0001,
    GWG_WAIT = 4'b0010,
    GWG_RUN  = 4'b0100,
    GWG_DONE = 4'b1000
  } gwg_state_e;

  typedef struct packed {
    logic [7:0]             lvl_lo;
    logic [3:0]             lvl_hi;
    logic [11:0]            dir;
    logic [3:0]             wide;
    logic [7:0]             div;
    logic [7:0]             dsel;
    logic [7:0]             frame;
    logic [7:0]             flash;
    logic [7:0]             chain;
    logic [7:0]             pause;
    logic [7:0]             abort;
    logic [11:0]            flags;
    logic [11:0]            mask;
    logic [7:0]             kind;
    logic [11:0]            edge_up;
    logic [7:0][7:0]        n;
    logic [4:0][7:0][7:0]   t;
    logic [15:0]            dcnt;
    gwg_state_e [7:0]       st;
    logic [7:0][2:0]        sub;
    logic [7:0][15:0]       cnt;
    logic [7:0][15:0]       rep;
    logic [7:0]             init;
    logic [7:0]             seen;
    logic [7:0]             done;
    logic [11:0]            in_s1;
    logic [11:0]            in_s2;
    logic [1:0]             fv_s;
    logic                   fv_q;
    logic [1:0]             sb_s;
    logic                   sb_q;
    logic [11:0]            prev;
    logic [7:0]             rd_data;
    logic                   wake;
  } gwg_state_s;
endpackage

// ---- rtl/gwg_top.sv ----
// twelve-pad output block with eight autonomous waveform generators
`timescale 1ns/1ps
`include "gwg_defines.svh"
module gwg_top
  import gwg_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        clk_on,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [11:0] pad_in,
  output logic      [11:0] pad_out,
  output logic      [11:0] pad_oe,
  input  wire logic        frame_valid,
  input  wire logic        strobe,
  output logic             mcu_wake
);
  gwg_state_s q;
  gwg_state_s d;

  // divider tick masks for both dividers
  logic [15:0] dmask0;
  logic [15:0] dmask1;
  logic [1:0]  dtick;
  assign dmask0 = 16'((17'h1 << (q.div[3:0] + 5'h1)) - 17'h1);
  assign dmask1 = 16'((17'h1 << (q.div[7:4] + 5'h1)) - 17'h1);
  assign dtick[0] = (q.dcnt & dmask0) == dmask0;
  assign dtick[1] = (q.dcnt & dmask1) == dmask1;

  // synchronized trigger edges
  logic fv_fall;
  logic sb_rise;
  assign fv_fall = q.fv_q & ~q.fv_s[1];
  assign sb_rise = ~q.sb_q & q.sb_s[1];

  // per-generator helpers, one copy for each of the eight waveform pads
  logic [7:0][15:0] sub_len;
  logic [7:0][15:0] rep_lim;
  logic [7:0]       ptick;
  logic [7:0]       pgo;
  logic [7:0]       odd_wide;
  for (genvar g = 0; g < 8; g++) begin : g_wave
    // odd pad of a wide pair carries no waveform
    assign odd_wide[g] = (g % 2 == 1) && q.wide[g / 2];

    assign ptick[g] = dtick[q.dsel[g]];

    // even pads may couple with their odd neighbour
    if (g % 2 == 0) begin : g_even
      // odd register gives the upper byte
      assign sub_len[g] = q.wide[g / 2] ? {q.t[q.sub[g]][g + 1], q.t[q.sub[g]][g]}
                                        : {8'h0, q.t[q.sub[g]][g]};
      // wide pairs also couple the repeat counts
      assign rep_lim[g] = q.wide[g / 2] ? {q.n[g + 1], q.n[g]}
                                        : {8'h0, q.n[g]};
    end else begin : g_odd
      // odd pads always count in eight bits
      assign sub_len[g] = {8'h0, q.t[q.sub[g]][g]};
      assign rep_lim[g] = {8'h0, q.n[g]};
    end

    // chain first, then frame, then flash
    assign pgo[g] = q.chain[g] ? q.done[(g + 7) % 8] :
                    q.frame[g] ? fv_fall :
                    q.flash[g] ? sb_rise :
                    1'b1;
  end

  // outputs come straight from flops
  assign pad_out   = {q.lvl_hi, q.lvl_lo};
  assign pad_oe    = q.dir;
  assign reg_rdata = q.rd_data;
  assign mcu_wake  = q.wake;

  // next-state logic for registers, generators and events
  always_comb begin
    logic [11:0] lvl;
    logic [11:0] cur;
    logic [11:0] ev;
    logic [11:0] w1c;
    logic [15:0] len;
    logic        tick;
    logic        go;
    logic        odd16;
    lvl   = 12'h0;
    cur   = 12'h0;
    ev    = 12'h0;
    w1c   = 12'h0;
    len   = 16'h0;
    tick  = 1'b0;
    go    = 1'b0;
    odd16 = 1'b0;
    d = q;

    // two-flop synchronizers for pins
    d.in_s1 = pad_in;
    d.in_s2 = q.in_s1;
    d.fv_s  = {q.fv_s[0], frame_valid};
    d.fv_q  = q.fv_s[1];
    d.sb_s  = {q.sb_s[0], strobe};
    d.sb_q  = q.sb_s[1];
    d.done  = 8'h0;
    d.wake  = 1'b0;

    // register writes
    lvl = {q.lvl_hi, q.lvl_lo};
    if (reg_wr) begin
      case (reg_addr)
        `GWG_A_LVL_LO: lvl[7:0]  = reg_wdata;
        `GWG_A_LVL_HI: lvl[11:8] = reg_wdata[3:0];
        // act on output bits set to one
        `GWG_A_SET_LO: lvl[7:0]  = lvl[7:0] | (reg_wdata & q.dir[7:0]);
        `GWG_A_TGL_LO: lvl[7:0]  = lvl[7:0] ^ (reg_wdata & q.dir[7:0]);
        `GWG_A_CLR_LO: lvl[7:0]  = lvl[7:0] & ~(reg_wdata & q.dir[7:0]);
        `GWG_A_SET_HI: lvl[11:8] = lvl[11:8] | (reg_wdata[3:0] & q.dir[11:8]);
        `GWG_A_TGL_HI: lvl[11:8] = lvl[11:8] ^ (reg_wdata[3:0] & q.dir[11:8]);
        `GWG_A_CLR_HI: lvl[11:8] = lvl[11:8] & ~(reg_wdata[3:0] & q.dir[11:8]);
        // direction and generator setup
        `GWG_A_DIR_LO: d.dir[7:0]  = reg_wdata;
        `GWG_A_DIR_HI: d.dir[11:8] = reg_wdata[3:0];
        `GWG_A_CFG:    d.wide      = reg_wdata[7:`GWG_CFG_LSB];
        `GWG_A_DIV:    d.div       = reg_wdata;
        `GWG_A_DSEL:   d.dsel      = reg_wdata;
        `GWG_A_FRAME:  d.frame     = reg_wdata;
        `GWG_A_FLASH:  d.flash     = reg_wdata;
        `GWG_A_CHAIN:  d.chain     = reg_wdata;
        `GWG_A_PAUSE:  d.pause     = reg_wdata;
        `GWG_A_ABORT:  d.abort     = reg_wdata;
        // notification flags and setup
        `GWG_A_FLG_LO: w1c[7:0]    = reg_wdata;
        `GWG_A_FLG_HI: w1c[11:8]   = reg_wdata[3:0];
        `GWG_A_MSK_LO: d.mask[7:0]  = reg_wdata;
        `GWG_A_MSK_HI: d.mask[11:8] = reg_wdata[3:0];
        `GWG_A_KIND:   d.kind       = reg_wdata;
        `GWG_A_EDG_LO: d.edge_up[7:0]  = reg_wdata;
        `GWG_A_EDG_HI: d.edge_up[11:8] = reg_wdata[3:0];
        default: begin
        end
      endcase
      // repeat counts and subperiod lengths
      for (int p = 0; p < 8; p++) begin
        if (reg_addr == 16'(`GWG_A_N_BASE + p)) begin
          d.n[p] = reg_wdata;
        end
        for (int i = 0; i < `GWG_SUBS; i++) begin
          if (reg_addr == 16'(`GWG_A_T_BASE + p * `GWG_SUBS + i)) begin
            d.t[i][p] = reg_wdata;
          end
        end
      end
    end

    // generators and dividers stop while the clock is gated
    if (clk_on) begin
      d.dcnt = q.dcnt + 16'h1;
    end

    // generators exist for pads 0-7 only
    for (int p = 0; p < 8; p++) begin
      // helpers of this pad from the generator block
      odd16 = odd_wide[p];
      tick  = ptick[p];
      len   = sub_len[p];
      go    = pgo[p];
      // abort clears counters and holds idle
      if (q.abort[p] || odd16) begin
        d.st[p]  = GWG_IDLE;
        d.sub[p] = 3'h0;
        d.cnt[p] = 16'h0;
        d.rep[p] = 16'h0;
        d.seen[p] = 1'b0;
      end else begin
        case (q.st[p])
          GWG_IDLE: begin
            // start only after pause is cleared
            if (!q.pause[p]) begin
              // initial level from the pad register
              d.init[p] = q.lvl_lo[p];
              d.sub[p]  = 3'h0;
              d.cnt[p]  = 16'h0;
              d.rep[p]  = 16'h0;
              d.seen[p] = 1'b0;
              // immediate start unless a trigger is chosen
              if (q.chain[p] || q.frame[p] || q.flash[p]) begin
                d.st[p] = GWG_WAIT;
              end else begin
                d.st[p] = GWG_RUN;
              end
            end
          end
          GWG_WAIT: begin
            if (q.pause[p]) begin
              d.st[p] = GWG_IDLE;
            end else if (go && clk_on) begin
              d.st[p] = GWG_RUN;
            end
          end
          GWG_RUN: begin
            if (!q.pause[p] && clk_on) begin
              // each period opens at initial level
              if (q.sub[p] == 3'h0 && !q.seen[p]) begin
                lvl[p]    = q.init[p];
                d.seen[p] = 1'b1;
              end
              if (len == 16'h0 || (tick && q.cnt[p] + 16'h1 >= len)) begin
                d.cnt[p] = 16'h0;
                if (q.sub[p] == `GWG_LAST_SUB) begin
                  d.sub[p]  = 3'h0;
                  d.seen[p] = 1'b0;
                  lvl[p]    = q.init[p];
                  d.rep[p]  = q.rep[p] + 16'h1;
                  if (rep_lim[p] != 16'h0 && q.rep[p] + 16'h1 >= rep_lim[p]) begin
                    d.st[p]   = GWG_DONE;
                    d.done[p] = 1'b1;
                  end
                end else begin
                  // nonzero subperiod ends with a flip
                  if (len != 16'h0) begin
                    lvl[p] = ~lvl[p];
                  end
                  d.sub[p] = q.sub[p] + 3'h1;
                end
              end else if (tick) begin
                d.cnt[p] = q.cnt[p] + 16'h1;
              end
            end
          end
          GWG_DONE: begin
            if (q.pause[p]) begin
              d.st[p] = GWG_IDLE;
            end
          end
          default: d.st[p] = GWG_IDLE;
        endcase
      end
    end

    // input pads mirror the synchronized pin level
    // applied last, so a generator never overrides an input pad
    lvl = (lvl & q.dir) | (q.in_s2 & ~q.dir);

    d.lvl_lo = lvl[7:0];
    d.lvl_hi = lvl[11:8];

    cur = lvl;
    d.prev = cur;
    for (int b = 0; b < 12; b++) begin
      if (b < 8 && !q.kind[b]) begin
        ev[b] = d.done[b];
      end else begin
        ev[b] = q.edge_up[b] ? (cur[b] & ~q.prev[b]) : (~cur[b] & q.prev[b]);
      end
    end
    // mask bit zero enables the event
    ev = ev & ~q.mask;
    // sticky flags, setting wins over clearing
    d.flags = (q.flags & ~w1c) | ev;
    d.wake  = |ev;

    // read data
    if (reg_rd) begin
      case (reg_addr)
        `GWG_A_LVL_LO: d.rd_data = q.lvl_lo;
        `GWG_A_LVL_HI: d.rd_data = {4'h0, q.lvl_hi};
        // direction and generator setup
        `GWG_A_DIR_LO: d.rd_data = q.dir[7:0];
        `GWG_A_DIR_HI: d.rd_data = {4'h0, q.dir[11:8]};
        `GWG_A_CFG:    d.rd_data = {q.wide, 4'h0};
        `GWG_A_DIV:    d.rd_data = q.div;
        `GWG_A_DSEL:   d.rd_data = q.dsel;
        `GWG_A_FRAME:  d.rd_data = q.frame;
        `GWG_A_FLASH:  d.rd_data = q.flash;
        `GWG_A_CHAIN:  d.rd_data = q.chain;
        `GWG_A_PAUSE:  d.rd_data = q.pause;
        `GWG_A_ABORT:  d.rd_data = q.abort;
        // notification registers
        `GWG_A_FLG_LO: d.rd_data = q.flags[7:0];
        `GWG_A_FLG_HI: d.rd_data = {4'h0, q.flags[11:8]};
        `GWG_A_MSK_LO: d.rd_data = q.mask[7:0];
        `GWG_A_MSK_HI: d.rd_data = {4'h0, q.mask[11:8]};
        `GWG_A_KIND:   d.rd_data = q.kind;
        `GWG_A_EDG_LO: d.rd_data = q.edge_up[7:0];
        `GWG_A_EDG_HI: d.rd_data = {4'h0, q.edge_up[11:8]};
        // command and unmapped addresses read zero
        default:       d.rd_data = 8'h0;
      endcase
      for (int p = 0; p < 8; p++) begin
        if (reg_addr == 16'(`GWG_A_N_BASE + p)) begin
          d.rd_data = q.n[p];
        end
        for (int i = 0; i < `GWG_SUBS; i++) begin
          if (reg_addr == 16'(`GWG_A_T_BASE + p * `GWG_SUBS + i)) begin
            d.rd_data = q.t[i][p];
          end
        end
      end
    end
  end

  // state register with synchronous reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      q       <= '0;
      q.st    <= {8{GWG_IDLE}};
      q.pause <= `GWG_PAUSE_RST;
      q.mask  <= `GWG_MASK_RST;
    end else begin
      q <= d;
    end
  end
endmodule

// ---- verif/gwg_chk.sv ----
// port checker of the pad waveform block
`timescale 1ns/1ps
`include "gwg_defines.svh"
module gwg_chk (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic [15:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [11:0] pad_out,
  input wire logic [11:0] pad_oe,
  input wire logic        mcu_wake
);
  // high pad slices and command strobes
  wire logic [3:0] ho     = pad_out[11:8];
  wire logic [3:0] hoe    = pad_oe[11:8];
  wire logic [3:0] wd     = reg_wdata[3:0];
  wire logic       wr_set = reg_wr && reg_addr == `GWG_A_SET_HI;
  wire logic       wr_tgl = reg_wr && reg_addr == `GWG_A_TGL_HI;
  wire logic       wr_clr = reg_wr && reg_addr == `GWG_A_CLR_HI;
  wire logic       wr_lvl = reg_wr && reg_addr == `GWG_A_LVL_HI;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_rst_quiet: assert property (disable iff (1'b0) reset |=>
    pad_out == 12'h000 && pad_oe == 12'h000 && reg_rdata == 8'h00 && !mcu_wake)
    else $error("outputs active after reset");
  a_tgl_hi_bits: assert property (wr_tgl |=> (ho & $past(hoe)) == (($past(ho) ^ $past(wd)) & $past(hoe)))
    else $error("high toggle command wrong");
  a_set_hi_bits: assert property (wr_set |=> (ho & $past(hoe)) == (($past(ho) | $past(wd)) & $past(hoe)))
    else $error("high set command wrong");
  a_clr_hi_bits: assert property (wr_clr |=> (ho & $past(hoe)) == (($past(ho) & ~$past(wd)) & $past(hoe)))
    else $error("high clear command wrong");
  a_lvl_hi_write: assert property (wr_lvl |=> (ho & hoe) == ($past(wd) & hoe))
    else $error("high level write not on pads");
  a_dir_hi_oe: assert property (reg_wr && reg_addr == `GWG_A_DIR_HI |=> hoe == $past(wd))
    else $error("direction write not on enables");
  a_cmd_read_zero: assert property (reg_rd && reg_addr inside {[`GWG_A_SET_LO:`GWG_A_CLR_HI]}
    |=> reg_rdata == 8'h00)
    else $error("command register holds a value");
  a_gap_read_zero: assert property (reg_rd && reg_addr == 16'h108a |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_pause_readback: assert property (reg_wr && reg_addr == `GWG_A_PAUSE ##2 reg_rd && reg_addr == `GWG_A_PAUSE
    |=> reg_rdata == $past(reg_wdata, 3))
    else $error("pause register readback wrong");

  c_wake: cover property (mcu_wake);
  c_tgl_hi: cover property (wr_tgl);
  c_flag_seen: cover property (reg_rd && reg_addr == `GWG_A_FLG_HI ##2 reg_rdata != 8'h00);
endmodule

// ---- verif/gwg_pad_model.sv ----
// actuator side of the pads: resolves each pad wire
`timescale 1ns/1ps
module gwg_pad_model (
  input  wire logic [11:0] pad_out,
  input  wire logic [11:0] pad_oe,
  input  wire logic [11:0] ext_lvl,
  output logic      [11:0] pad_in
);
  // driven pads show the block, others the actuator
  always_comb pad_in = (pad_out & pad_oe) | (ext_lvl & ~pad_oe);
endmodule

// ---- verif/tb_gwg_top.sv ----
// self-checking bench of the pad waveform block
`timescale 1ns/1ps
`include "gwg_defines.svh"
module tb_gwg_top;
  logic        core_clk    = 1'b0;
  logic        reset       = 1'b1;
  logic [15:0] reg_addr    = 16'h0000;
  logic        reg_wr      = 1'b0;
  logic [7:0]  reg_wdata   = 8'h00;
  logic        reg_rd      = 1'b0;
  logic [11:0] ext_lvl     = 12'h000;
  logic        frame_valid = 1'b1;
  logic        strobe      = 1'b0;
  logic        clk_on      = 1'b1;
  logic [7:0]  reg_rdata;
  logic [11:0] pad_in;
  logic [11:0] pad_out;
  logic [11:0] pad_oe;
  logic        mcu_wake;
  logic [11:0] dir;
  logic [11:0] lvl;
  logic [11:0] m;
  logic [7:0]  v;
  logic [15:0] a;
  logic [7:0]  tt [5] = '{8'h03, 8'h02, 8'h05, 8'h01, 8'h04};
  int          tq [$];
  int          n1 = 0;
  int          wakes = 0;
  int          w0;
  int          mismatches = 0;
  int          checks = 0;

  always #4 core_clk = ~core_clk;

  gwg_top gwg_top_inst (
    .core_clk    (core_clk),
    .reset       (reset),
    .clk_on      (clk_on),
    .reg_addr    (reg_addr),
    .reg_wr      (reg_wr),
    .reg_wdata   (reg_wdata),
    .reg_rd      (reg_rd),
    .reg_rdata   (reg_rdata),
    .pad_in      (pad_in),
    .pad_out     (pad_out),
    .pad_oe      (pad_oe),
    .frame_valid (frame_valid),
    .strobe      (strobe),
    .mcu_wake    (mcu_wake)
  );
  gwg_pad_model gwg_pad_model_inst (
    .pad_out (pad_out),
    .pad_oe  (pad_oe),
    .ext_lvl (ext_lvl),
    .pad_in  (pad_in)
  );

  // wake pulses and pad edges seen by the bench
  always @(posedge core_clk) if (mcu_wake === 1'b1) wakes++;
  always @(pad_out[0]) if (!reset) tq.push_back(int'($time / 8));
  always @(pad_out[1]) if (!reset) n1++;

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    #1 reg_addr = ad;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1 reg_wr = 1'b0;
  endtask

  task automatic rchk(input logic [15:0] ad, input logic [7:0] e);
    @(posedge core_clk);
    #1 reg_addr = ad;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #1 reg_rd = 1'b0;
    @(posedge core_clk);
    #1 chk({4'h0, reg_rdata}, {4'h0, e});
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // watchdog against a hung run
  initial begin
    #(4000 * 8);
    mismatches++;
    finish_test;
  end

  initial begin
    void'($urandom(40));
    repeat (3) @(posedge core_clk);
    #1 reset = 1'b0;
    chk(pad_oe, 12'h000);
    rchk(`GWG_A_PAUSE, 8'hff);
    rchk(`GWG_A_MSK_HI, 8'h0f);
    rchk(16'h108a, 8'h00);
    $display("test reset done");
    ext_lvl = 12'($urandom);
    dir = 12'($urandom) | 12'h10b;
    lvl = 12'($urandom);
    wr(`GWG_A_DIR_LO, dir[7:0]);
    wr(`GWG_A_DIR_HI, {4'h0, dir[11:8]});
    wr(`GWG_A_LVL_LO, lvl[7:0]);
    wr(`GWG_A_LVL_HI, {4'h0, lvl[11:8]});
    lvl = (lvl & dir) | (ext_lvl & ~dir);
    rchk(`GWG_A_LVL_HI, {4'h0, lvl[11:8]});
    chk(pad_out, lvl);
    // set, toggle and clear on both halves with random masks
    for (int k = 0; k < 6; k++) begin
      v = 8'($urandom);
      a = `GWG_A_SET_LO + 16'(k);
      m = (k < 3) ? {4'h0, v} : {v[3:0], 8'h00};
      m = m & dir;
      wr(a, v);
      if (k % 3 == 0) lvl = lvl | m;
      else if (k % 3 == 1) lvl = lvl ^ m;
      else lvl = lvl & ~m;
      rchk(a, 8'h00);
      chk(pad_out, lvl);
    end
    wr(`GWG_A_TGL_LO, 8'h08);
    lvl[3] = ~lvl[3];
    rchk(`GWG_A_LVL_LO, lvl[7:0]);
    $display("test commands done");
    wr(`GWG_A_CLR_HI, 8'h01);
    wr(`GWG_A_EDG_HI, 8'h01);
    wr(`GWG_A_MSK_HI, 8'h0e);
    w0 = wakes;
    wr(`GWG_A_SET_HI, 8'h01);
    rchk(`GWG_A_FLG_HI, 8'h01);
    chk(12'(wakes - w0), 12'h001);
    wr(`GWG_A_FLG_HI, 8'h01);
    wr(`GWG_A_CLR_HI, 8'h01);
    rchk(`GWG_A_FLG_HI, 8'h00);
    $display("test events done");
    // pad 0: two periods of five subperiods, divider ratio 2
    wr(`GWG_A_CLR_LO, 8'h01);
    for (int i = 0; i < 5; i++) wr(`GWG_A_T_BASE + 16'(i), tt[i]);
    wr(`GWG_A_N_BASE, 8'h02);
    wr(`GWG_A_MSK_LO, 8'hfe);
    tq.delete();
    w0 = wakes;
    wr(`GWG_A_PAUSE, 8'hfe);
    repeat (100) @(posedge core_clk);
    #1 chk(12'(tq.size()), 12'h008);
    for (int i = 0; i < 3; i++) chk(12'(tq[i + 1] - tq[i]), 12'(2 * tt[i + 1]));
    chk(12'(tq[4] - tq[3]), 12'(2 * (tt[4] + tt[0])));
    chk({11'h000, pad_out[0]}, 12'h000);
    rchk(`GWG_A_FLG_LO, 8'h01);
    chk(12'(wakes - w0), 12'h001);
    $display("test waveform done");
    // pad 1 waits on frame although flash is also selected
    for (int i = 5; i < 10; i++) wr(`GWG_A_T_BASE + 16'(i), 8'h01);
    wr(`GWG_A_N_BASE + 16'h0001, 8'h01);
    wr(`GWG_A_FRAME, 8'h02);
    wr(`GWG_A_FLASH, 8'h02);
    wr(`GWG_A_PAUSE, 8'hfc);
    rchk(`GWG_A_PAUSE, 8'hfc);
    n1 = 0;
    strobe = 1'b1;
    repeat (20) @(posedge core_clk);
    #1 chk(12'(n1), 12'h000);
    frame_valid = 1'b0;
    repeat (30) @(posedge core_clk);
    #1 chk(12'(n1), 12'h004);
    $display("test triggers done");
    // pad 0 restarted with the clock gated, then released
    clk_on = 1'b0;
    wr(`GWG_A_PAUSE, 8'hff);
    wr(`GWG_A_PAUSE, 8'hfe);
    tq.delete();
    repeat (20) @(posedge core_clk);
    #1 chk(12'(tq.size()), 12'h000);
    clk_on = 1'b1;
    repeat (100) @(posedge core_clk);
    #1 chk(12'(tq.size()), 12'h008);
    $display("test clock gate done");
    finish_test;
  end
endmodule

bind gwg_top gwg_chk gwg_chk_inst (
  .core_clk  (core_clk),
  .reset     (reset),
  .reg_addr  (reg_addr),
  .reg_wr    (reg_wr),
  .reg_wdata (reg_wdata),
  .reg_rd    (reg_rd),
  .reg_rdata (reg_rdata),
  .pad_out   (pad_out),
  .pad_oe    (pad_oe),
  .mcu_wake  (mcu_wake)
);
